// ### design/fsi_pkg.sv
/*
  Shared constants for the status indicator block: tick timing, pattern
  phase lengths, drive state word bit positions, error code values and history depth.
  Assumes a 200 MHz system clock.
*/
`default_nettype none
package fsi_pkg;
  // ----------------------------------------
  // Clock and tick
  // ----------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int TICK_US = 1000;
  localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
  // ----------------------------------------
  // Pattern phase lengths in milliseconds
  // ----------------------------------------
  localparam logic [10:0] FLICKER_MS = 11'h032;
  localparam logic [10:0] BLINK_MS = 11'h0c8;
  localparam logic [10:0] FLASH_ON_MS = 11'h0c8;
  localparam logic [10:0] FLASH_GAP_MS = 11'h0c8;
  localparam logic [10:0] FLASH_OFF_MS = 11'h3e8;
  // ----------------------------------------
  // Drive state word and command word bits
  // ----------------------------------------
  localparam int SW_FAULT_BIT = 3;
  localparam int SW_WARN_BIT = 7;
  localparam int SW_REMOTE_BIT = 9;
  localparam int CW_FAULT_RESET_BIT = 7;
  // ----------------------------------------
  // Codes and history
  // ----------------------------------------
  localparam int HIST_DEPTH = 8;
  localparam logic [15:0] CODE_NONE = 16'h0000;
  localparam logic [15:0] CODE_PD_WATCHDOG = 16'h001b;
  // Lamp patterns
  typedef enum logic [2:0] {
    PAT_OFF, PAT_ON, PAT_FLICKER, PAT_BLINK, PAT_SINGLE, PAT_DOUBLE
  } fsi_pat_type;
  // Slave network states
  typedef enum logic [1:0] {
    NET_INIT, NET_PREOP, NET_SAFEOP, NET_OP
  } fsi_net_type;
endpackage
`default_nettype wire

// ### design/fsi_lamp.sv
/*
  One lamp pattern generator. Steps through the phases of the selected
  pattern on a shared millisecond tick.
  Assumes tick is a one-cycle pulse in the clk domain.
*/
`default_nettype none
module fsi_lamp (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Timing and selection
  input wire logic tick,
  input wire fsi_pkg::fsi_pat_type pattern,
  // Lamp drive
  output logic lamp
);
  // ----------------------------------------
  // Phase state
  // ----------------------------------------
  logic [10:0] msCnt_q;       // Milliseconds spent in current phase
  logic [1:0] phase_q;        // Phase index within pattern
  fsi_pkg::fsi_pat_type patPrev_q; // Pattern seen last cycle
  logic lamp_q;
  logic [10:0] phaseLen;      // Length of current phase
  logic [1:0] lastPhase;      // Final phase index of pattern
  logic phaseLit;             // Whether current phase lights
  logic changed;
  logic phaseEnd;

  assign changed = pattern != patPrev_q;
  // Phase table; flicker and blink are two phases, double flash four
  assign phaseLen = (pattern == fsi_pkg::PAT_FLICKER) ? fsi_pkg::FLICKER_MS :
                    (pattern == fsi_pkg::PAT_BLINK) ? fsi_pkg::BLINK_MS :
                    (phase_q == 2'h0) ? fsi_pkg::FLASH_ON_MS :
                    (pattern == fsi_pkg::PAT_SINGLE) ? fsi_pkg::FLASH_OFF_MS :
                    (phase_q == 2'h1) ? fsi_pkg::FLASH_GAP_MS :
                    (phase_q == 2'h2) ? fsi_pkg::FLASH_ON_MS :
                    fsi_pkg::FLASH_OFF_MS;
  assign lastPhase = (pattern == fsi_pkg::PAT_DOUBLE) ? 2'h3 : 2'h1;
  assign phaseLit = (phase_q == 2'h0) || (phase_q == 2'h2);
  assign phaseEnd = tick && (msCnt_q == phaseLen - 11'h001);

  // Phase walker; restarts at the lit phase on any pattern change
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      msCnt_q <= 11'h000;
      phase_q <= 2'h0;
      patPrev_q <= fsi_pkg::PAT_OFF;
    end else begin
      patPrev_q <= pattern;
      if (changed) begin
        msCnt_q <= 11'h000;
        phase_q <= 2'h0;
      end else if (phaseEnd) begin
        msCnt_q <= 11'h000;
        phase_q <= (phase_q == lastPhase) ? 2'h0 : phase_q + 2'h1;
      end else if (tick) begin
        msCnt_q <= msCnt_q + 11'h001;
      end
    end
  end

  // Registered lamp output
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lamp_q <= 1'b0;
    end else begin
      case (pattern)
        fsi_pkg::PAT_OFF: lamp_q <= 1'b0;
        fsi_pkg::PAT_ON: lamp_q <= 1'b1;
        default: lamp_q <= phaseLit && !changed;
      endcase
    end
  end
  assign lamp = lamp_q;

  // Flicker lit phase lasts exactly the flicker length in ticks
  property p_flicker_len;
    @(posedge clk) disable iff (!reset_n)
      (pattern == fsi_pkg::PAT_FLICKER && !changed && phaseEnd && phase_q == 2'h0)
      |=> (phase_q == 2'h1 && msCnt_q == 11'h000);
  endproperty
  a_flicker_len: assert property (p_flicker_len)
    else $error("flicker phase did not advance");

  // A pattern change restarts at phase zero
  property p_restart;
    @(posedge clk) disable iff (!reset_n)
      changed |=> (phase_q == 2'h0 && msCnt_q == 11'h000);
  endproperty
  a_restart: assert property (p_restart)
    else $error("pattern change did not restart");

  // Single flash never reaches phase two
  property p_single_two;
    @(posedge clk) disable iff (!reset_n)
      (pattern == fsi_pkg::PAT_SINGLE && $stable(pattern)) |-> phase_q < 2'h2;
  endproperty
  a_single_two: assert property (p_single_two)
    else $error("single flash used too many phases");
endmodule
`default_nettype wire

// ### design/fieldbus_status_indicator.sv
/*
  Status indicator and error reporting for a fieldbus slave card on a
  motor inverter: state, error and per-port link lamps, drive state word
  bits, emergency events, error code objects and an eight-entry history.
  Assumes all inputs are synchronous to clk; the protocol stack supplies
  network state and error events, the inverter supplies trip and warning.
*/
// Contract
// - Flicker: 50 ms lit, 50 ms dark
// - Blink: 200 ms lit, 200 ms dark
// - Single flash: 200 lit, 1000 dark
// - Double flash: 200/200/200 lit-dark-lit, 1000 dark
// - Link lamp dark without physical link
// - Link lamp flickers once link is up
// - State lamp dark in Init
// - State lamp blinks in Pre-Operational
// - State lamp single flash in Safe-Operational
// - Operational: state lamp on, error dark
// - Hardware error forces state lamp dark
// - Error lamp: config blink, timeout double
// - Trip enters Fault; master bit 7 clears
// - Warning sets state word bit 7
// - Bit 9 clear when not network controllable
// - Emergency on fault or warning, not comms
// - Current error code published for reads
// - Inverter error code in own object
// - Eight-entry diagnosis history of errors
// - Watchdog timeout in Operational reports 0x001B
`default_nettype none
module fieldbus_status_indicator #(
  parameter int TICK_CYCLES = fsi_pkg::TICK_CYCLES,
  parameter int PORTS = 2,
  parameter int DEPTH = fsi_pkg::HIST_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Network side
  input wire fsi_pkg::fsi_net_type netState,
  input wire logic [PORTS-1:0] linkUp,
  input wire logic hwError,
  input wire logic cfgError,
  input wire logic pdTimeout,
  input wire logic errClear,
  input wire logic [15:0] commandWord,
  // Inverter side
  input wire logic invTrip,
  input wire logic invWarn,
  input wire logic invCommError,
  input wire logic localOverride,
  input wire logic invLinkLost,
  input wire logic [15:0] invErrorCode,
  // Lamps
  output logic runLamp,
  output logic errLamp,
  output logic [PORTS-1:0] linkLamp,
  // Status word and events
  output logic [15:0] statusBits,
  output logic emergency,
  output logic [15:0] errorCode,
  output logic [15:0] invCodeObj,
  output logic [15:0] statusCode,
  // History read port
  input wire logic [2:0] histIndex,
  output logic [15:0] histData,
  output logic [3:0] histCount
);
  // ----------------------------------------
  // Millisecond tick
  // ----------------------------------------
  // One shared tick keeps all lamps phase-coherent and saves counters
  localparam int TW = $clog2(TICK_CYCLES);
  logic [TW-1:0] tickCnt_q;
  logic tick;
  assign tick = tickCnt_q == TW'(TICK_CYCLES - 1);

  // Free running prescaler
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tickCnt_q <= '0;
    end else begin
      tickCnt_q <= tick ? '0 : tickCnt_q + TW'(1);
    end
  end

  // ----------------------------------------
  // Error lamp condition tracking
  // ----------------------------------------
  // Latest-wins: remember which condition rose last while both active
  logic cfgPrev_q, pdPrev_q;
  logic lastIsPd_q;            // Most recent rise was the timeout
  logic cfgRise, pdRise;
  assign cfgRise = cfgError && !cfgPrev_q;
  assign pdRise = pdTimeout && !pdPrev_q;

  // Edge history of the two error conditions
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cfgPrev_q <= 1'b0;
      pdPrev_q <= 1'b0;
      lastIsPd_q <= 1'b0;
    end else begin
      cfgPrev_q <= cfgError;
      pdPrev_q <= pdTimeout;
      if (pdRise) begin
        lastIsPd_q <= 1'b1;
      end else if (cfgRise) begin
        lastIsPd_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Pattern selection
  // ----------------------------------------
  fsi_pkg::fsi_pat_type runPat, errPat;
  assign runPat = hwError ? fsi_pkg::PAT_OFF :
                  (netState == fsi_pkg::NET_INIT) ? fsi_pkg::PAT_OFF :
                  (netState == fsi_pkg::NET_PREOP) ? fsi_pkg::PAT_BLINK :
                  (netState == fsi_pkg::NET_SAFEOP) ? fsi_pkg::PAT_SINGLE :
                  fsi_pkg::PAT_ON;
  // Timeout and config error win over normal-operation dark lamp
  assign errPat = (pdTimeout && (lastIsPd_q || !cfgError)) ? fsi_pkg::PAT_DOUBLE :
                  cfgError ? fsi_pkg::PAT_BLINK :
                  fsi_pkg::PAT_OFF;

  // State lamp generator
  fsi_lamp uRun (
    .clk(clk),
    .reset_n(reset_n),
    .tick(tick),
    .pattern(runPat),
    .lamp(runLamp)
  );
  // Error lamp generator
  fsi_lamp uErr (
    .clk(clk),
    .reset_n(reset_n),
    .tick(tick),
    .pattern(errPat),
    .lamp(errLamp)
  );
  // Link lamps, one per port; no activity input, so link up flickers
  genvar gi;
  generate
    for (gi = 0; gi < PORTS; gi++) begin : gLink
      fsi_pkg::fsi_pat_type linkPat;
      assign linkPat = linkUp[gi] ? fsi_pkg::PAT_FLICKER : fsi_pkg::PAT_OFF;
      fsi_lamp uLink (
        .clk(clk),
        .reset_n(reset_n),
        .tick(tick),
        .pattern(linkPat),
        .lamp(linkLamp[gi])
      );
    end
  endgenerate

  // ----------------------------------------
  // Drive state word
  // ----------------------------------------
  logic fault_q, faultPrev_q, warnPrev_q;
  logic faultReset;
  logic emerg_q;
  logic [15:0] status_q;
  // Reset only takes once the trip cause has gone
  assign faultReset = commandWord[fsi_pkg::CW_FAULT_RESET_BIT] && !invTrip;

  // Fault latch: a trip wins over a reset in the same cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fault_q <= 1'b0;
    end else if (invTrip) begin
      fault_q <= 1'b1;
    end else if (faultReset) begin
      fault_q <= 1'b0;
    end
  end

  // Registered state word bits
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      status_q <= 16'h0000;
    end else begin
      status_q <= 16'h0000;
      status_q[fsi_pkg::SW_FAULT_BIT] <= fault_q || invTrip;
      status_q[fsi_pkg::SW_WARN_BIT] <= invWarn;
      status_q[fsi_pkg::SW_REMOTE_BIT] <= !(localOverride || invLinkLost);
    end
  end
  assign statusBits = status_q;

  // ----------------------------------------
  // Emergency and error codes
  // ----------------------------------------
  logic trigEmerg;
  // Communication errors suppress the emergency; statusCode reports only the watchdog timeout
  assign trigEmerg = ((invTrip && !faultPrev_q) || (invWarn && !warnPrev_q))
                     && !invCommError;
  logic [15:0] err_q, inv_q, al_q;

  // Event pulse and code holders
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      faultPrev_q <= 1'b0;
      warnPrev_q <= 1'b0;
      emerg_q <= 1'b0;
      err_q <= fsi_pkg::CODE_NONE;
      inv_q <= fsi_pkg::CODE_NONE;
      al_q <= fsi_pkg::CODE_NONE;
    end else begin
      faultPrev_q <= invTrip;
      warnPrev_q <= invWarn;
      emerg_q <= trigEmerg;
      inv_q <= invErrorCode;
      if (invTrip || invWarn) begin
        err_q <= invErrorCode;
      end else if (faultReset) begin
        err_q <= fsi_pkg::CODE_NONE;
      end
      if (pdTimeout && netState == fsi_pkg::NET_OP) begin
        al_q <= fsi_pkg::CODE_PD_WATCHDOG;
      end else if (errClear) begin
        al_q <= fsi_pkg::CODE_NONE;
      end
    end
  end
  assign emergency = emerg_q;
  assign errorCode = err_q;
  assign invCodeObj = inv_q;
  assign statusCode = al_q;

  // ----------------------------------------
  // Diagnosis history
  // ----------------------------------------
  // Ring of the latest entries; oldest is overwritten once full
  logic [15:0] hist_q [DEPTH];
  logic [2:0] wrPtr_q;
  logic [3:0] count_q;
  logic hwPrev_q;
  logic histWrite;
  logic [15:0] histCode;
  assign histWrite = (invTrip && !faultPrev_q) || (hwError && !hwPrev_q) || pdRise;
  assign histCode = (invTrip && !faultPrev_q) ? invErrorCode :
                    pdRise ? fsi_pkg::CODE_PD_WATCHDOG : 16'h0001;

  // History storage and pointers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wrPtr_q <= 3'h0;
      count_q <= 4'h0;
      hwPrev_q <= 1'b0;
      for (int i = 0; i < DEPTH; i++) begin
        hist_q[i] <= 16'h0000;
      end
    end else begin
      hwPrev_q <= hwError;
      if (histWrite) begin
        hist_q[wrPtr_q] <= histCode;
        wrPtr_q <= wrPtr_q + 3'h1;
        if (count_q != 4'(DEPTH)) begin
          count_q <= count_q + 4'h1;
        end
      end
    end
  end
  assign histData = hist_q[histIndex];
  assign histCount = count_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_fault_word;
    @(posedge clk) disable iff (!reset_n)
      invTrip |=> ##1 statusBits[fsi_pkg::SW_FAULT_BIT];
  endproperty
  a_fault_word: assert property (p_fault_word)
    else $error("trip not shown in state word");

  property p_warn_word;
    @(posedge clk) disable iff (!reset_n)
      invWarn |=> statusBits[fsi_pkg::SW_WARN_BIT];
  endproperty
  a_warn_word: assert property (p_warn_word)
    else $error("warning bit not set");

  property p_remote_word;
    @(posedge clk) disable iff (!reset_n)
      localOverride |=> !statusBits[fsi_pkg::SW_REMOTE_BIT];
  endproperty
  a_remote_word: assert property (p_remote_word)
    else $error("remote bit set under override");

  property p_emerg;
    @(posedge clk) disable iff (!reset_n)
      (invWarn && !$past(invWarn) && !invTrip && !invCommError) |=> emergency;
  endproperty
  a_emerg: assert property (p_emerg)
    else $error("no emergency on warning");

  property p_no_emerg_comm;
    @(posedge clk) disable iff (!reset_n)
      invCommError |=> !emergency;
  endproperty
  a_no_emerg_comm: assert property (p_no_emerg_comm)
    else $error("emergency on comm error");

  property p_watchdog;
    @(posedge clk) disable iff (!reset_n)
      (pdTimeout && netState == fsi_pkg::NET_OP) |=> statusCode == fsi_pkg::CODE_PD_WATCHDOG;
  endproperty
  a_watchdog: assert property (p_watchdog)
    else $error("watchdog code missing");

  property p_hw_dark;
    @(posedge clk) disable iff (!reset_n)
      hwError [*2] |-> !runLamp;
  endproperty
  a_hw_dark: assert property (p_hw_dark)
    else $error("state lamp lit under hardware error");

  property p_hist;
    @(posedge clk) disable iff (!reset_n)
      (histWrite && count_q < 4'(DEPTH)) |=> count_q == $past(count_q) + 4'h1;
  endproperty
  a_hist: assert property (p_hist)
    else $error("history count not advanced");
endmodule
`default_nettype wire

// ### dv/fsi_inverter_model.sv
/*
  Behavioural inverter standing behind the status indicator: trip and
  warning levels with the inverter's own error code.
  Assumes the bench raises requests just after a rising clk edge.
*/
`default_nettype none
module fsi_inverter_model (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Requests from the bench
  input wire logic tripReq,
  input wire logic warnReq,
  input wire logic [15:0] codeReq,
  // Inverter status toward the card
  output logic invTrip,
  output logic invWarn,
  output logic [15:0] invErrorCode
);
  timeunit 1ns;
  timeprecision 100ps;
  // Status lines move one edge after a request, like a registered output
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      invTrip <= 1'b0;
      invWarn <= 1'b0;
      invErrorCode <= 16'h0000;
    end else begin
      // Trip stays up until the cause is removed; only then may it be reset
      invTrip <= tripReq;
      invWarn <= warnReq;
      // Code reads zero when healthy, so no stale value can pass for a match
      invErrorCode <= (tripReq || warnReq) ? codeReq : 16'h0000;
    end
  end
endmodule
`default_nettype wire

// ### dv/fieldbus_status_indicator_test.sv
/*
  Self-checking bench for the status indicator: lamp patterns, state word,
  emergency events, code objects and the diagnosis history.
  Assumes the design is built with a short millisecond tick.
*/
`default_nettype none
module fieldbus_status_indicator_test;
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  localparam int TK = 4; // Clocks per ms; keeps 1 s patterns short
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  fsi_pkg::fsi_net_type netState = fsi_pkg::NET_INIT;
  logic [1:0] linkUp = 2'h0;
  logic hwError = 1'b0, cfgError = 1'b0, pdTimeout = 1'b0, errClear = 1'b0;
  logic [15:0] commandWord = 16'h0000, codeReq = 16'h0000;
  logic invCommError = 1'b0, localOverride = 1'b0, invLinkLost = 1'b0;
  logic tripReq = 1'b0, warnReq = 1'b0, invTrip, invWarn, emergency;
  logic [2:0] histIndex = 3'h0;
  logic runLamp, errLamp;
  logic [1:0] linkLamp;
  logic [15:0] invErrorCode, statusBits, errorCode, invCodeObj, statusCode, histData;
  logic [3:0] histCount;
  logic [15:0] histExp [8]; // Expected ring contents
  int miscompares = 0, check_count = 0, emCount = 0, histN = 0;
  // Half-period toggle gives 200 MHz
  always #2.5 clk = ~clk;
  // Emergency pulses are counted, so a doubled pulse shows up too
  always @(posedge clk) if (emergency === 1'b1) emCount <= emCount + 1;
  // ----------------------------------------
  // Device and far side
  // ----------------------------------------
  fieldbus_status_indicator #(.TICK_CYCLES(TK), .PORTS(2), .DEPTH(8)) uut (
    .clk(clk), .reset_n(reset_n), .netState(netState), .linkUp(linkUp),
    .hwError(hwError), .cfgError(cfgError), .pdTimeout(pdTimeout), .errClear(errClear),
    .commandWord(commandWord), .invTrip(invTrip), .invWarn(invWarn),
    .invCommError(invCommError), .localOverride(localOverride), .invLinkLost(invLinkLost),
    .invErrorCode(invErrorCode), .runLamp(runLamp), .errLamp(errLamp), .linkLamp(linkLamp),
    .statusBits(statusBits), .emergency(emergency), .errorCode(errorCode),
    .invCodeObj(invCodeObj), .statusCode(statusCode), .histIndex(histIndex),
    .histData(histData), .histCount(histCount));
  fsi_inverter_model inv (
    .clk(clk), .reset_n(reset_n), .tripReq(tripReq), .warnReq(warnReq),
    .codeReq(codeReq), .invTrip(invTrip), .invWarn(invWarn), .invErrorCode(invErrorCode));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic lampOf(input int sel);
    case (sel)
      0: return runLamp;
      1: return errLamp;
      default: return linkLamp[sel-2];
    endcase
  endfunction
  // Bounded wait for a lamp level; n returns the cycles it took
  task automatic waitLvl(input int sel, input logic val, input int lim, output int n);
    n = 0;
    while (lampOf(sel) !== val) begin
      @(negedge clk);
      n++;
      if (n > lim) begin
        miscompares++;
        $display("Error lamp %0d expected %b seen %b", sel, val, lampOf(sel));
        wrap_up();
      end
    end
  endtask
  // Restart must show within a few clocks; first lit phase may be short
  task automatic measure(input string what, input int sel, input int first,
                         input int a, input int b, input int c, input int d, input int k);
    int n;
    int ms [4];
    ms = '{a, b, c, d};
    // Look only once the selection edge has settled, never in its own time step
    @(negedge clk);
    waitLvl(sel, 1'b0, 4, n);
    waitLvl(sel, 1'b1, 4, n);
    waitLvl(sel, 1'b0, (first + 1) * TK, n);
    for (int i = 0; i < k; i++) begin
      waitLvl(sel, (i % 2 == 0), ms[i] * TK + 4, n);
      check(what, 16'(n), 16'(ms[i] * TK));
    end
  endtask
  task automatic holdLamp(input int sel, input logic val, input int n);
    repeat (n) @(negedge clk) check("lamp level", 16'(lampOf(sel)), 16'(val));
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic logEntry(input logic [15:0] c);
    histExp[histN % 8] = c;
    histN++;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    int base;
    repeat (20) @(posedge clk);
    check("lamps in reset", 16'({runLamp, errLamp, linkLamp, emergency}), 16'h0000);
    check("statusBits in reset", statusBits, 16'h0000);
    @(posedge clk) reset_n <= 1'b1;
    settle(3);
    check("statusBits idle", statusBits, 16'h0200);
    $display("Test reset done");
    // Link lamps: dark without link, flicker once up
    holdLamp(2, 1'b0, 40);
    @(posedge clk) linkUp <= 2'b01;
    measure("link flicker", 2, 50, 50, 50, 0, 0, 2);
    check("linkLamp idle port", 16'(linkLamp[1]), 16'h0000);
    @(posedge clk) linkUp <= 2'b11;
    measure("link flicker port 1", 3, 50, 50, 50, 0, 0, 2);
    $display("Test link done");
    // State lamp through the network states
    holdLamp(0, 1'b0, 40);
    @(posedge clk) netState <= fsi_pkg::NET_PREOP;
    measure("run blink", 0, 200, 200, 200, 0, 0, 2);
    @(posedge clk) netState <= fsi_pkg::NET_SAFEOP;
    measure("run single", 0, 200, 1000, 200, 0, 0, 2);
    @(posedge clk) netState <= fsi_pkg::NET_OP;
    settle(4);
    repeat (3 * TK) @(negedge clk) check("op lamps", 16'({runLamp, errLamp}), 16'h0002);
    @(posedge clk) hwError <= 1'b1;
    logEntry(16'h0001);
    settle(3);
    holdLamp(0, 1'b0, 3 * TK);
    @(posedge clk) hwError <= 1'b0;
    $display("Test state lamp done");
    // Error lamp: latest condition wins
    @(posedge clk) cfgError <= 1'b1;
    measure("err blink", 1, 200, 200, 200, 0, 0, 2);
    @(posedge clk) pdTimeout <= 1'b1;
    logEntry(16'h001b);
    measure("err double", 1, 200, 200, 200, 1000, 200, 4);
    check("statusCode", statusCode, 16'h001b);
    // Config error rising again while the timeout stands must take over
    @(posedge clk) cfgError <= 1'b0;
    @(posedge clk) cfgError <= 1'b1;
    measure("err latest", 1, 200, 200, 200, 0, 0, 2);
    @(posedge clk);
    pdTimeout <= 1'b0;
    cfgError <= 1'b0;
    errClear <= 1'b1;
    @(posedge clk) errClear <= 1'b0;
    settle(3);
    check("statusCode cleared", statusCode, 16'h0000);
    check("errLamp off", 16'(errLamp), 16'h0000);
    $display("Test error lamp done");
    // Warning, trip and fault reset
    base = emCount;
    @(posedge clk);
    warnReq <= 1'b1;
    codeReq <= 16'h0a05;
    settle(4);
    check("statusBits warn", statusBits, 16'h0280);
    check("emergency warn", 16'(emCount - base), 16'h0001);
    check("errorCode", errorCode, 16'h0a05);
    check("invCodeObj", invCodeObj, 16'h0a05);
    @(posedge clk) warnReq <= 1'b0;
    settle(3);
    check("statusBits unwarn", statusBits, 16'h0200);
    base = emCount;
    @(posedge clk);
    invCommError <= 1'b1;
    tripReq <= 1'b1;
    codeReq <= 16'h0b07;
    logEntry(16'h0b07);
    settle(4);
    check("emergency comms", 16'(emCount - base), 16'h0000);
    check("statusBits trip", statusBits, 16'h0208);
    check("errorCode trip", errorCode, 16'h0b07);
    @(posedge clk);
    tripReq <= 1'b0;
    invCommError <= 1'b0;
    settle(4);
    check("fault latched", statusBits, 16'h0208);
    @(posedge clk) commandWord <= 16'h0080;
    settle(3);
    check("fault reset", statusBits, 16'h0200);
    check("errorCode reset", errorCode, 16'h0000);
    @(posedge clk) tripReq <= 1'b1;
    logEntry(16'h0b07);
    settle(4);
    check("trip beats reset", statusBits, 16'h0208);
    @(posedge clk) tripReq <= 1'b0;
    settle(4);
    check("reset after cause", statusBits, 16'h0200);
    @(posedge clk);
    commandWord <= 16'h0000;
    localOverride <= 1'b1;
    settle(3);
    check("override", statusBits, 16'h0000);
    @(posedge clk);
    localOverride <= 1'b0;
    invLinkLost <= 1'b1;
    settle(3);
    check("link lost", statusBits, 16'h0000);
    @(posedge clk) invLinkLost <= 1'b0;
    $display("Test state word done");
    // History ring wraps past eight entries
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      tripReq <= 1'b1;
      codeReq <= 16'h0c00 + 16'(i);
      logEntry(16'h0c00 + 16'(i));
      repeat (3) @(posedge clk);
      tripReq <= 1'b0;
      repeat (3) @(posedge clk);
      commandWord <= 16'h0080;
      repeat (3) @(posedge clk);
      commandWord <= 16'h0000;
    end
    settle(3);
    check("histCount", 16'(histCount), 16'h0008);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk) histIndex <= 3'(i);
      @(negedge clk) check("histData", histData, histExp[i]);
    end
    $display("Test history done");
    wrap_up();
  end
endmodule
`default_nettype wire
